// File: verilog/mhc_pkg.sv
// Purpose: Shared constants for the MAC host control block
// Assumes: 200 MHz core clock, 8-bit I/O offsets, 16-bit registers
// Notes:   Offsets are the I/O addresses used by the host port

package mhc_pkg;
	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] OFF_TX_POLL   = 8'h14;
	localparam logic [7:0] OFF_RX_BUFSZ  = 8'h18;
	localparam logic [7:0] OFF_RX_DESC   = 8'h1A;
	localparam logic [7:0] OFF_LAST_STAT = 8'h1C;
	localparam logic [7:0] OFF_MGMT_CTRL = 8'h20;
	localparam logic [7:0] OFF_MGMT_RD   = 8'h24;
	localparam logic [7:0] OFF_MGMT_WR   = 8'h28;
	localparam logic [7:0] OFF_TXB_LO    = 8'h2C;
	localparam logic [7:0] OFF_TXB_HI    = 8'h30;
	localparam logic [7:0] OFF_RXB_LO    = 8'h34;
	localparam logic [7:0] OFF_RXB_HI    = 8'h38;
	localparam logic [7:0] OFF_INT_STAT  = 8'h3C;

	// ****************************************
	// Reset values and field layouts
	// ****************************************
	localparam logic [15:0] RST_RX_BUFSZ   = 16'h0600;
	localparam int          BIT_WR_GO      = 14;
	localparam int          BIT_RD_GO      = 13;
	localparam int          BIT_LINK_LEVEL = 11;
	localparam logic [15:0] LAST_STAT_MASK = 16'hE6FF;
	localparam logic [9:0]  INT_STAT_MASK  = 10'h39F;
	localparam int          INT_LINK_BIT   = 9;
	localparam int          INT_TX_DONE    = 4;
	localparam int          INT_RX_DONE    = 0;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS   = 5;
	localparam int MDC_HALF_NS     = 200;
	localparam int MDC_HALF_CYC    =
		(MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MDIO_FRAME_BITS = 64;
	localparam int MDIO_TA_BIT     = 46;
	localparam int MDIO_DATA_BIT   = 48;

	// ****************************************
	// Buffering
	// ****************************************
	localparam int STAT_FIFO_WIDTH = 16;
	localparam int STAT_FIFO_DEPTH = 32;
endpackage

// File: verilog/mhc_fifo_if.sv
// Purpose: Valid/ready carrier between the status FIFO and the top
// Assumes: Single clock domain
// Notes:   FIFO side and user side each have a modport, each carrying both fill and drain signals

`timescale 1ns/1ps
`default_nettype none

interface mhc_fifo_if #(parameter int WIDTH = 16);
	logic             in_valid;
	logic             in_ready;
	logic [WIDTH-1:0] in_data;
	logic             out_valid;
	logic             out_ready;
	logic [WIDTH-1:0] out_data;

	modport fifo (input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data);
	modport user (output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data);
endinterface

`default_nettype wire

// File: verilog/mhc_fifo.sv
// Purpose: Packet status FIFO, flip-flop storage
// Assumes: Single clock, async active-low reset
// Notes:   Full and empty come from an occupancy counter

`timescale 1ns/1ps
`default_nettype none

module mhc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic core_clk_i,
	input  wire logic rst_n_i,
	mhc_fifo_if.fifo  bus
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_idx_reg;
	logic [AW-1:0]    rd_idx_reg;
	logic [AW:0]      count_reg;
	wire              push;
	wire              pop;

	assign bus.in_ready  = (count_reg != (AW+1)'(DEPTH));
	assign bus.out_valid = (count_reg != '0);
	assign bus.out_data  = mem_reg[rd_idx_reg];
	assign push          = bus.in_valid & bus.in_ready;
	assign pop           = bus.out_valid & bus.out_ready;

	always_ff @(posedge core_clk_i) begin
		if (push)
			mem_reg[wr_idx_reg] <= bus.in_data;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_idx_reg <= '0;
			rd_idx_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push)
				wr_idx_reg <= wr_idx_reg + 1'b1;
			if (pop)
				rd_idx_reg <= rd_idx_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // mhc_fifo

`default_nettype wire

// File: verilog/mhc_top.sv
// Purpose: Host control/status registers and MDIO master of the MAC
// Assumes: Host I/O strobes and MAC events synchronous to core_clk_i
// Notes:   Reads answer one cycle after the strobe, from a flop
//
// What this block does
// - Poll write makes MAC wait for owner bit 1, then transmit.
// - Reading poll bit gives 1 while transmitting, 0 when done.
// - Buffer size reset 0600h, bits 10..2 writable, low bits zero.
// - Pause frame requested when available count falls to threshold.
// - With receive enabled, each finished receive descriptor decrements available count.
// - With receive enabled, a count write adds the written value.
// - With receive disabled, a count write loads the value.
// - Last status holds latest packet status, overwritten by next.
// - Last status flags at bits 15,14,13,10,9,7..0, read only.
// - Last status bit 11 shows the link change pin level.
// - Write go sends write word to addressed PHY register, self-clears.
// - Read go fetches PHY register into read word, self-clears.
// - Transmit base is 20 bits from high and low; bit 0 reads 0.
// - Transmit base advances to next descriptor after transmission.
// - Receive base is 20 bits from high and low; bit 0 reads 0.
// - Receive base advances to next descriptor after reception.
// - Interrupt status bits 9,8,7,4,3,2,1,0 set on their events.
// - Reading interrupt status returns flags and clears them.
// - Receive enable gates the descriptor count only; receive base advance and interrupt do not depend on it.
// - Descriptor owner bit 1 means MAC owns it, 0 the CPU.

`timescale 1ns/1ps
`default_nettype none

module mhc_top (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  io_addr_i,
	input  wire logic        io_wr_i,
	input  wire logic        io_rd_i,
	input  wire logic [15:0] io_wdata_i,
	output logic      [15:0] io_rdata_o,
	input  wire logic        receive_enable_i,
	input  wire logic        tx_owner_i,
	output logic             tx_start_o,
	input  wire logic        tx_done_i,
	input  wire logic [19:0] tx_next_desc_i,
	input  wire logic        rx_pkt_done_i,
	input  wire logic [19:0] rx_next_desc_i,
	input  wire logic        rx_desc_done_i,
	output logic             pause_req_o,
	output logic      [10:0] rx_buffer_size_o,
	output logic      [19:0] tx_desc_addr_o,
	output logic      [19:0] rx_desc_addr_o,
	input  wire logic [15:0] pkt_status_i,
	input  wire logic        pkt_status_valid_i,
	output logic             pkt_status_ready_o,
	input  wire logic [9:0]  irq_event_i,
	input  wire logic        link_change_input_i,
	output logic             mdc_o,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	input  wire logic        mdio_i
);
	// ****************************************
	// Types and storage
	// ****************************************
	typedef enum logic {MD_IDLE, MD_RUN} mhc_md_state_t;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	logic          poll_pend_reg;
	logic          tx_busy_reg;
	logic [8:0]    bufsz_reg;
	logic [7:0]    thresh_reg;
	logic [7:0]    avail_reg;
	logic [7:0]    avail_next;
	logic [15:0]   last_stat_reg;
	logic [9:0]    int_stat_reg;
	logic [9:0]    int_stat_next;
	logic          link_prev_reg;
	logic [15:1]   txb_lo_reg;
	logic [3:0]    txb_hi_reg;
	logic [15:1]   rxb_lo_reg;
	logic [3:0]    rxb_hi_reg;
	logic [15:0]   mg_wdata_reg;
	logic [15:0]   mg_rdata_reg;
	logic [4:0]    phy_addr_reg;
	logic [4:0]    phy_reg_reg;
	logic          op_read_reg;
	mhc_md_state_t md_state_reg;
	logic [7:0]    div_reg;
	logic          mdc_reg;
	logic [5:0]    bit_idx_reg;
	logic [15:0]   rd_shift_reg;

	// ****************************************
	// Address decode
	// ****************************************
	wire wr_poll  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_TX_POLL);
	wire wr_bufsz = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_RX_BUFSZ);
	wire wr_desc  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_RX_DESC);
	wire wr_mctl  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_MGMT_CTRL);
	wire wr_mwd   = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_MGMT_WR);
	wire wr_txlo  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_TXB_LO);
	wire wr_txhi  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_TXB_HI);
	wire wr_rxlo  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_RXB_LO);
	wire wr_rxhi  = io_wr_i & hit(io_addr_i, mhc_pkg::OFF_RXB_HI);
	wire rd_isr   = io_rd_i & hit(io_addr_i, mhc_pkg::OFF_INT_STAT);
	wire rd_last  = io_rd_i & hit(io_addr_i, mhc_pkg::OFF_LAST_STAT);

	// ****************************************
	// Transmit poll
	// ****************************************
	// Owner bit 1 hands the descriptor to the MAC
	assign tx_start_o = poll_pend_reg & tx_owner_i;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			poll_pend_reg <= 1'b0;
			tx_busy_reg   <= 1'b0;
		end else begin
			if (tx_start_o)
				poll_pend_reg <= 1'b0;
			else if (wr_poll && io_wdata_i[0])
				poll_pend_reg <= 1'b1;
			if (tx_start_o)
				tx_busy_reg <= 1'b1;
			else if (tx_done_i)
				tx_busy_reg <= 1'b0;
		end
	end

	// ****************************************
	// Receive buffer size and descriptor count
	// ****************************************
	assign rx_buffer_size_o = {bufsz_reg, 2'b00};

	wire dec_ev = rx_desc_done_i & receive_enable_i;
	// Add and decrement in the same cycle both count
	always_comb begin
		avail_next = avail_reg;
		if (wr_desc && receive_enable_i)
			avail_next = avail_reg + io_wdata_i[7:0];
		else if (wr_desc)
			avail_next = io_wdata_i[7:0];
		if (dec_ev)
			avail_next = avail_next - 8'h01;
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bufsz_reg   <= mhc_pkg::RST_RX_BUFSZ[10:2];
			thresh_reg  <= 8'h00;
			avail_reg   <= 8'h00;
			pause_req_o <= 1'b0;
		end else begin
			if (wr_bufsz)
				bufsz_reg <= io_wdata_i[10:2];
			if (wr_desc)
				thresh_reg <= io_wdata_i[15:8];
			avail_reg   <= avail_next;
			// Only a fall to the threshold asks for pause
			pause_req_o <= dec_ev && avail_next == thresh_reg;
		end
	end

	// ****************************************
	// Packet status FIFO and last status
	// ****************************************
	mhc_fifo_if #(.WIDTH(mhc_pkg::STAT_FIFO_WIDTH)) stat_if ();

	mhc_fifo #(
		.WIDTH(mhc_pkg::STAT_FIFO_WIDTH),
		.DEPTH(mhc_pkg::STAT_FIFO_DEPTH)
	) u_stat_fifo (
		.core_clk_i(core_clk_i),
		.rst_n_i   (rst_n_i),
		.bus       (stat_if.fifo)
	);

	assign stat_if.in_valid  = pkt_status_valid_i;
	assign stat_if.in_data   = pkt_status_i;
	assign pkt_status_ready_o = stat_if.in_ready;
	// Drain stalls on a status read so the host sees a stable word
	assign stat_if.out_ready = ~rd_last;

	wire       stat_pop = stat_if.out_valid & stat_if.out_ready;
	wire [15:0] last_view = (last_stat_reg & mhc_pkg::LAST_STAT_MASK) |
		(16'(link_change_input_i) << mhc_pkg::BIT_LINK_LEVEL);

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			last_stat_reg <= 16'h0000;
		else if (stat_pop)
			last_stat_reg <= stat_if.out_data;
	end

	// ****************************************
	// Descriptor base pointers
	// ****************************************
	assign tx_desc_addr_o = {txb_hi_reg, txb_lo_reg, 1'b0};
	assign rx_desc_addr_o = {rxb_hi_reg, rxb_lo_reg, 1'b0};

	// Hardware advance wins over a host write in the same cycle
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			txb_lo_reg <= '0;
			txb_hi_reg <= '0;
			rxb_lo_reg <= '0;
			rxb_hi_reg <= '0;
		end else begin
			if (tx_done_i) begin
				txb_lo_reg <= tx_next_desc_i[15:1];
				txb_hi_reg <= tx_next_desc_i[19:16];
			end else begin
				if (wr_txlo)
					txb_lo_reg <= io_wdata_i[15:1];
				if (wr_txhi)
					txb_hi_reg <= io_wdata_i[3:0];
			end
			if (rx_pkt_done_i) begin
				rxb_lo_reg <= rx_next_desc_i[15:1];
				rxb_hi_reg <= rx_next_desc_i[19:16];
			end else begin
				if (wr_rxlo)
					rxb_lo_reg <= io_wdata_i[15:1];
				if (wr_rxhi)
					rxb_hi_reg <= io_wdata_i[3:0];
			end
		end
	end

	// ****************************************
	// Interrupt status, read to clear
	// ****************************************
	wire [9:0] int_ev = (irq_event_i
		| (10'(link_change_input_i ^ link_prev_reg) << mhc_pkg::INT_LINK_BIT)
		| (10'(tx_done_i) << mhc_pkg::INT_TX_DONE)
		| (10'(rx_pkt_done_i) << mhc_pkg::INT_RX_DONE))
		& mhc_pkg::INT_STAT_MASK;
	// Event landing on the clearing read survives
	assign int_stat_next = (rd_isr ? 10'h000 : int_stat_reg) | int_ev;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_stat_reg  <= 10'h000;
			link_prev_reg <= 1'b0;
		end else begin
			int_stat_reg  <= int_stat_next;
			link_prev_reg <= link_change_input_i;
		end
	end

	// ****************************************
	// MDIO management master
	// ****************************************
	wire md_busy  = (md_state_reg == MD_RUN);
	wire md_start = wr_mctl & ~md_busy &
		(io_wdata_i[mhc_pkg::BIT_WR_GO] | io_wdata_i[mhc_pkg::BIT_RD_GO]);
	wire md_tick  = md_busy && div_reg == 8'(mhc_pkg::MDC_HALF_CYC - 1);
	wire md_rise  = md_tick & ~mdc_reg;
	wire md_fall  = md_tick & mdc_reg;
	wire md_last  = bit_idx_reg == 6'(mhc_pkg::MDIO_FRAME_BITS - 1);
	wire md_done  = md_fall & md_last;
	wire [31:0] md_frame = {2'b01, op_read_reg, ~op_read_reg,
		phy_addr_reg, phy_reg_reg, 2'b10, mg_wdata_reg};

	assign mdc_o     = mdc_reg;
	assign mdio_o    = bit_idx_reg[5] ? md_frame[~bit_idx_reg[4:0]] : 1'b1;
	// Release the line for turnaround and data on reads
	assign mdio_oe_o = md_busy & ~(op_read_reg &&
		bit_idx_reg >= 6'(mhc_pkg::MDIO_TA_BIT));

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			md_state_reg <= MD_IDLE;
			op_read_reg  <= 1'b0;
			phy_addr_reg <= '0;
			phy_reg_reg  <= '0;
			mg_wdata_reg <= 16'h0000;
			mg_rdata_reg <= 16'h0000;
			div_reg      <= 8'h00;
			mdc_reg      <= 1'b0;
			bit_idx_reg  <= 6'h00;
			rd_shift_reg <= 16'h0000;
		end else begin
			if (wr_mwd)
				mg_wdata_reg <= io_wdata_i;
			if (wr_mctl && !md_busy) begin
				phy_addr_reg <= io_wdata_i[12:8];
				phy_reg_reg  <= io_wdata_i[4:0];
				op_read_reg  <= ~io_wdata_i[mhc_pkg::BIT_WR_GO];
			end
			div_reg <= (md_tick || !md_busy) ? 8'h00 : div_reg + 8'h01;
			if (md_start) begin
				md_state_reg <= MD_RUN;
				bit_idx_reg  <= 6'h00;
				mdc_reg      <= 1'b0;
			end else if (md_rise) begin
				mdc_reg <= 1'b1;
				if (bit_idx_reg >= 6'(mhc_pkg::MDIO_DATA_BIT))
					rd_shift_reg <= {rd_shift_reg[14:0], mdio_i};
			end else if (md_done) begin
				mdc_reg      <= 1'b0;
				md_state_reg <= MD_IDLE;
				if (op_read_reg)
					mg_rdata_reg <= rd_shift_reg;
			end else if (md_fall) begin
				mdc_reg     <= 1'b0;
				bit_idx_reg <= bit_idx_reg + 6'h01;
			end
		end
	end

	// ****************************************
	// Read data path
	// ****************************************
	logic [15:0] rd_mux;
	always_comb begin
		unique case (io_addr_i)
			mhc_pkg::OFF_TX_POLL:
				rd_mux = {15'h0000, tx_busy_reg | poll_pend_reg};
			mhc_pkg::OFF_RX_BUFSZ:  rd_mux = {5'h00, rx_buffer_size_o};
			mhc_pkg::OFF_RX_DESC:   rd_mux = {thresh_reg, avail_reg};
			mhc_pkg::OFF_LAST_STAT: rd_mux = last_view;
			mhc_pkg::OFF_MGMT_CTRL:
				rd_mux = {1'b0, md_busy & ~op_read_reg, md_busy & op_read_reg,
					phy_addr_reg, 3'h0, phy_reg_reg};
			mhc_pkg::OFF_MGMT_RD:   rd_mux = mg_rdata_reg;
			mhc_pkg::OFF_MGMT_WR:   rd_mux = mg_wdata_reg;
			mhc_pkg::OFF_TXB_LO:    rd_mux = tx_desc_addr_o[15:0];
			mhc_pkg::OFF_TXB_HI:    rd_mux = {12'h000, txb_hi_reg};
			mhc_pkg::OFF_RXB_LO:    rd_mux = rx_desc_addr_o[15:0];
			mhc_pkg::OFF_RXB_HI:    rd_mux = {12'h000, rxb_hi_reg};
			mhc_pkg::OFF_INT_STAT:  rd_mux = {6'h00, int_stat_reg};
			default:                rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			io_rdata_o <= 16'h0000;
		else if (io_rd_i)
			io_rdata_o <= rd_mux;
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	poll_waits_a: assert property (
		poll_pend_reg && !tx_owner_i |=> poll_pend_reg)
		else $error("poll request lost while owner bit clear");
	poll_read_a: assert property (
		tx_start_o |=> tx_busy_reg until_with tx_done_i)
		else $error("transmit state dropped before completion");
	bufsz_low_a: assert property (
		wr_bufsz |=> rx_buffer_size_o == {$past(io_wdata_i[10:2]), 2'b00})
		else $error("buffer size write not taken with low bits zero");
	pause_thresh_a: assert property (
		pause_req_o |-> avail_reg == thresh_reg && $past(dec_ev))
		else $error("pause without reaching threshold");
	desc_dec_a: assert property (
		dec_ev && !wr_desc |=> avail_reg == $past(avail_reg) - 8'h01)
		else $error("descriptor count not decremented");
	desc_add_a: assert property (
		wr_desc && receive_enable_i && !rx_desc_done_i
		|=> avail_reg == $past(avail_reg) + $past(io_wdata_i[7:0]))
		else $error("count write did not add");
	desc_load_a: assert property (
		wr_desc && !receive_enable_i |=> avail_reg == $past(io_wdata_i[7:0]))
		else $error("count write did not load");
	link_level_a: assert property (
		rd_last |=> io_rdata_o[11] == $past(link_change_input_i))
		else $error("link level bit wrong");
	isr_clear_a: assert property (
		rd_isr && int_ev == 10'h000 |=> int_stat_reg == 10'h000)
		else $error("interrupt status not cleared by read");
	tx_base_a: assert property (
		tx_done_i |=> tx_desc_addr_o == {$past(tx_next_desc_i[19:1]), 1'b0})
		else $error("transmit base not advanced");
	md_ignore_a: assert property (
		wr_mctl && md_busy |=> $stable(phy_addr_reg) && $stable(op_read_reg))
		else $error("command accepted while busy");

	tx_cycle_c: cover property (tx_start_o ##[1:20] tx_done_i);
	pause_c:    cover property (pause_req_o);
	md_done_c:  cover property (md_done && op_read_reg);
	fifo_full_c: cover property (!pkt_status_ready_o);
endmodule // mhc_top

`default_nettype wire

// File: verification/mhc_phy_model.sv
// Purpose: MDIO PHY model on the management link
// Assumes: Frames of 64 MDC periods, MDC idle low
// Notes:   Drives turnaround and data on MDC fall

`timescale 1ns/1ps
`default_nettype none

module mhc_phy_model (
	input  wire logic        mdc_i,
	input  wire logic        mdio_i,
	input  wire logic [15:0] rd_word_i,
	output logic             mdio_o,
	output logic             mdio_oe_o,
	output logic      [31:0] frame_o
);
	int          cnt = 0;
	logic        rd_op = 1'b0;
	logic [31:0] sh = 32'h0;

	initial begin
		mdio_o = 1'b0;
		mdio_oe_o = 1'b0;
		frame_o = 32'h0;
	end

	// ****************************************
	// Frame capture on MDC rise
	// ****************************************
	always @(posedge mdc_i) begin
		sh = {sh[30:0], mdio_i};
		cnt = (cnt + 1) % 64;
		if (cnt == 36) rd_op = sh[1:0] == 2'b10;
		if (cnt == 0) frame_o = sh;
	end

	// Drives only after the master has let go at turnaround
	always @(negedge mdc_i) begin
		mdio_oe_o = rd_op && cnt >= 47;
		mdio_o = cnt == 47 ? 1'b0 : rd_word_i[(63 - cnt) % 16];
	end
endmodule // mhc_phy_model

`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the MAC host control block
// Assumes: Inputs change on the falling edge, 200 MHz clock
// Notes:   Each MDIO frame takes about 5120 clocks

`timescale 1ns/1ps
`default_nettype none

module tb_top;
	// ****************************************
	// Signals
	// ****************************************
	logic        core_clk_i, rst_n_i, io_wr_i, io_rd_i, tx_start_o;
	logic [7:0]  io_addr_i;
	logic [15:0] io_wdata_i, io_rdata_o, pkt_status_i, rd_word;
	logic        receive_enable_i, tx_owner_i, tx_done_i, pause_req_o;
	logic [19:0] tx_next_desc_i, rx_next_desc_i;
	logic [19:0] tx_desc_addr_o, rx_desc_addr_o;
	logic        rx_pkt_done_i, rx_desc_done_i;
	logic [10:0] rx_buffer_size_o;
	logic        pkt_status_valid_i, pkt_status_ready_o;
	logic [9:0]  irq_event_i;
	logic        link_change_input_i, mdc_o, mdio_o, mdio_oe_o, mdio_i;
	logic        phy_d, phy_oe;
	logic [31:0] frame;
	int          n_errors = 0, checks_done = 0, n_pause = 0, n_start = 0;

	// Shared MDIO wire with pull-up
	assign mdio_i = mdio_oe_o ? mdio_o : (phy_oe ? phy_d : 1'b1);

	mhc_top dut (.core_clk_i, .rst_n_i, .io_addr_i, .io_wr_i, .io_rd_i,
		.io_wdata_i, .io_rdata_o, .receive_enable_i, .tx_owner_i,
		.tx_start_o, .tx_done_i, .tx_next_desc_i, .rx_pkt_done_i,
		.rx_next_desc_i, .rx_desc_done_i, .pause_req_o,
		.rx_buffer_size_o, .tx_desc_addr_o, .rx_desc_addr_o,
		.pkt_status_i, .pkt_status_valid_i, .pkt_status_ready_o,
		.irq_event_i, .link_change_input_i, .mdc_o, .mdio_o,
		.mdio_oe_o, .mdio_i);
	mhc_phy_model phy (.mdc_i(mdc_o), .mdio_i(mdio_i), .rd_word_i(rd_word),
		.mdio_o(phy_d), .mdio_oe_o(phy_oe), .frame_o(frame));

	always @(posedge core_clk_i) begin
		if (pause_req_o === 1'b1) n_pause++;
		if (tx_start_o === 1'b1) n_start++;
	end

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk_i);
		io_addr_i = a;
		io_wdata_i = d;
		io_wr_i = 1'b1;
		@(negedge core_clk_i);
		io_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge core_clk_i);
		io_addr_i = a;
		io_rd_i = 1'b1;
		@(negedge core_clk_i);
		io_rd_i = 1'b0;
		@(negedge core_clk_i);
	endtask
	task automatic rc(input logic [7:0] a, input logic [15:0] e);
		rd(a);
		chk("io_rdata_o", {16'h0, e}, {16'h0, io_rdata_o});
	endtask
	task automatic pulse(ref logic s);
		@(negedge core_clk_i);
		s = 1'b1;
		@(negedge core_clk_i);
		s = 1'b0;
	endtask
	task automatic push(input logic [15:0] d);
		pkt_status_i = d;
		pkt_status_valid_i = 1'b1;
		@(negedge core_clk_i);
	endtask
	task automatic mdio_wait();
		int i;
		i = 0;
		do begin
			rd(8'h20);
			i++;
		end while (io_rdata_o[14:13] !== 2'b00 && i < 4000);
		// A frame that never ends counts as a mismatch
		if (io_rdata_o[14:13] !== 2'b00) n_errors++;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset();
		rc(8'h18, 16'h0600);
		rc(8'h1A, 16'h0000);
		rc(8'h1C, 16'h0000);
		rc(8'h40, 16'h0000);
		chk("bufsz", 32'h600, {21'h0, rx_buffer_size_o});
		wr(8'h18, 16'hFFFF);
		rc(8'h18, 16'h07FC);
		chk("bufsz", 32'h7FC, {21'h0, rx_buffer_size_o});
	endtask
	task automatic t_desc();
		wr(8'h1A, 16'h0203);
		rc(8'h1A, 16'h0203);
		receive_enable_i = 1'b1;
		wr(8'h1A, 16'h0202);
		rc(8'h1A, 16'h0205);
		repeat (3) pulse(rx_desc_done_i);
		rc(8'h1A, 16'h0202);
		chk("pause", 32'h1, n_pause);
		receive_enable_i = 1'b0;
		pulse(rx_desc_done_i);
		rc(8'h1A, 16'h0202);
	endtask
	task automatic t_poll();
		wr(8'h14, 16'h0001);
		repeat (4) @(negedge core_clk_i);
		chk("tx_start", 32'h0, n_start);
		rc(8'h14, 16'h0001);
		tx_owner_i = 1'b1;
		repeat (3) @(negedge core_clk_i);
		chk("tx_start", 32'h1, n_start);
		tx_owner_i = 1'b0;
		rc(8'h14, 16'h0001);
		tx_next_desc_i = 20'hABCD8;
		pulse(tx_done_i);
		rc(8'h14, 16'h0000);
		chk("tx_desc", 32'hABCD8, {12'h0, tx_desc_addr_o});
		rc(8'h2C, 16'hBCD8);
	endtask
	task automatic t_base();
		wr(8'h2C, 16'hFFFF);
		wr(8'h30, 16'hFFFF);
		rc(8'h2C, 16'hFFFE);
		rc(8'h30, 16'h000F);
		chk("tx_desc", 32'hFFFFE, {12'h0, tx_desc_addr_o});
		wr(8'h34, 16'h1235);
		wr(8'h38, 16'h0007);
		chk("rx_desc", 32'h71234, {12'h0, rx_desc_addr_o});
		receive_enable_i = 1'b1;
		rx_next_desc_i = 20'h5A5A4;
		pulse(rx_pkt_done_i);
		receive_enable_i = 1'b0;
		rc(8'h34, 16'hA5A4);
		rc(8'h38, 16'h0005);
	endtask
	task automatic t_stat();
		link_change_input_i = 1'b1;
		chk("ready", 32'h1, {31'h0, pkt_status_ready_o});
		push(16'hFFFF);
		push(16'h1201);
		pkt_status_valid_i = 1'b0;
		rc(8'h1C, 16'h0A01);
		push(16'hFFFF);
		pkt_status_valid_i = 1'b0;
		rc(8'h1C, 16'hEEFF);
		link_change_input_i = 1'b0;
		// Read-only: this write must leave the word as it is
		wr(8'h1C, 16'h0000);
		rc(8'h1C, 16'hE6FF);
	endtask
	task automatic t_irq();
		rd(8'h3C);
		irq_event_i = 10'h3FF;
		@(negedge core_clk_i);
		irq_event_i = 10'h000;
		rc(8'h3C, 16'h039F);
		rc(8'h3C, 16'h0000);
		link_change_input_i = 1'b1;
		rc(8'h3C, 16'h0200);
	endtask
	task automatic t_mdio();
		wr(8'h28, 16'hA55A);
		wr(8'h20, 16'h530B);
		wr(8'h20, 16'h2104);
		rc(8'h20, 16'h530B);
		mdio_wait();
		rc(8'h20, 16'h130B);
		chk("frame", {4'h5, 5'h13, 5'h0B, 2'b10, 16'hA55A}, frame);
		rd_word = 16'h3C96;
		wr(8'h20, 16'h2A05);
		mdio_wait();
		rc(8'h24, 16'h3C96);
		rc(8'h20, 16'h0A05);
		chk("frame", {4'h6, 5'h0A, 5'h05, 2'b10, 16'h3C96}, frame);
	endtask

	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, reset, sequence, watchdog
	// ****************************************
	initial begin
		core_clk_i = 1'b0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	initial begin
		{rst_n_i, io_wr_i, io_rd_i, io_addr_i, io_wdata_i} = '0;
		{receive_enable_i, tx_owner_i, tx_done_i, rx_pkt_done_i} = '0;
		{rx_desc_done_i, pkt_status_valid_i, link_change_input_i} = '0;
		{tx_next_desc_i, rx_next_desc_i, pkt_status_i} = '0;
		irq_event_i = 10'h000;
		rd_word = 16'h0000;
		repeat (3) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		t_reset();
		t_desc();
		t_poll();
		t_base();
		t_stat();
		t_irq();
		t_mdio();
		conclude();
	end
	// Two MDIO frames dominate, about 52 us in all
	initial begin
		#200000;
		n_errors++;
		conclude();
	end
endmodule // tb_top

`default_nettype wire
